/* verilog/meter_display_control.v */
`timescale 1ns/10ps
`default_nettype none
`include "meter_display_defines.vh"

module meter_display_control (
    // Clock and reset
    input  wire       i_core_clk,
    input  wire       i_rstn,
    // Timebase, one cycle per second
    input  wire       i_sec_tick,
    // Front-panel buttons, raw pins, high while pressed
    input  wire       i_btn_scroll,
    input  wire       i_btn_select,
    // Display setup
    input  wire       i_cfg_wr,
    input  wire [3:0] i_backlight_min,
    input  wire       i_backlight_cont,
    input  wire       i_autoret_en,
    input  wire [4:0] i_autoret_min,
    input  wire       i_autoscroll_en,
    input  wire [4:0] i_scroll_sec,
    input  wire [6:0] i_scroll_incl,
    input  wire [3:0] i_energy_digits,
    // Meter mode and context
    input  wire       i_test_mode,
    input  wire       i_setup_active,
    input  wire       i_pt_ratio_gt1,
    // Page counts
    input  wire [3:0] i_bill_reg_cnt,
    input  wire [3:0] i_dmd_reg_cnt,
    input  wire [3:0] i_tariff_cnt,
    input  wire [19:0] i_disp_pages,
    // Display state
    output reg        o_backlight,
    output reg  [2:0] o_display,
    output reg  [7:0] o_page,
    output reg        o_autoscroll,
    output reg        o_setup_exit,
    output reg        o_test_label,
    // Units and resolution
    output reg  [1:0] o_energy_unit,
    output reg  [1:0] o_energy_frac,
    output reg  [3:0] o_energy_digits,
    output reg  [1:0] o_power_unit,
    output reg  [1:0] o_power_frac,
    output reg  [1:0] o_volt_unit,
    output reg  [1:0] o_volt_frac,
    output reg  [1:0] o_curr_unit,
    output reg  [1:0] o_curr_frac,
    output reg  [1:0] o_test_energy_frac
);

    localparam ST_MANUAL = 1'b0;
    localparam ST_SCROLL = 1'b1;

    // ----------------------------------------
    // Page count of a display slot
    // ----------------------------------------
    function [7:0] pages_of;
        input [2:0]  slot;
        input        test;
        input [3:0]  bill_regs;
        input [3:0]  dmd_regs;
        input [3:0]  tariffs;
        input [19:0] pages;
        reg   [7:0]  per_reg;
        begin
            per_reg = {4'h0, tariffs} + 8'h01;
            case (slot)
                3'h0: begin
                    if (test)
                        pages_of = 8'h01;
                    else
                        pages_of = {4'h0, bill_regs} * per_reg;
                end
                3'h1: begin
                    if (test)
                        pages_of = 8'h00;
                    else
                        pages_of = {4'h0, dmd_regs} * per_reg;
                end
                3'h2: pages_of = {4'h0, pages[3:0]};
                3'h3: pages_of = {4'h0, pages[7:4]};
                3'h4: pages_of = {4'h0, pages[11:8]};
                3'h5: pages_of = {4'h0, pages[15:12]};
                3'h6: pages_of = {4'h0, pages[19:16]};
                default: pages_of = 8'h00;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Button events
    // ----------------------------------------
    wire press_scroll;
    wire press_select;
    wire any_press;

    button_sync u_sync_scroll (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_btn      (i_btn_scroll),
        .o_press    (press_scroll)
    );

    button_sync u_sync_select (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_btn      (i_btn_select),
        .o_press    (press_select)
    );

    assign any_press = press_scroll | press_select;

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg        state_q;
    reg [3:0]  bl_min_q;
    reg [4:0]  ar_min_q;
    reg [4:0]  scr_s_q;
    reg [10:0] idle_q;
    reg [4:0]  step_q;
    reg [2:0]  slot_q;
    reg [7:0]  page_q;
    reg [2:0]  res_slot_q;
    reg [7:0]  res_page_q;

    // ----------------------------------------
    // Idle limits
    // ----------------------------------------
    wire [10:0] idle_nx;
    wire [10:0] bl_lim;
    wire [10:0] ar_lim;
    wire [10:0] start_lim;
    wire [4:0]  ar_sel;
    wire [4:0]  step_nx;

    assign idle_nx   = (idle_q == `MDC_IDLE_MAX) ? idle_q : idle_q + 11'h001;
    assign bl_lim    = {7'h00, bl_min_q} * `MDC_SEC_PER_MIN;
    assign ar_sel    = i_setup_active ? `MDC_SETUP_RET_MIN : ar_min_q;
    assign ar_lim    = {6'h00, ar_sel} * `MDC_SEC_PER_MIN;
    assign start_lim = {6'h00, `MDC_SCROLL_START_MIN} * `MDC_SEC_PER_MIN;
    assign step_nx   = step_q + 5'h01;

    // ----------------------------------------
    // Next position
    // ----------------------------------------
    reg [7:0] cur_pages;
    reg [2:0] nxt_slot;
    reg [3:0] cand;
    reg       found;
    reg       last_page;
    integer   k;

    always @* begin
        cur_pages = pages_of(slot_q, i_test_mode, i_bill_reg_cnt, i_dmd_reg_cnt,
                             i_tariff_cnt, i_disp_pages);
        last_page = ({1'b0, page_q} + 9'h001) >= {1'b0, cur_pages};
        nxt_slot  = slot_q;
        found     = 1'b0;
        cand      = 4'h0;
        // Fixed order, wrapping after the last display
        for (k = 1; k < 8; k = k + 1) begin
            cand = {1'b0, slot_q} + k[3:0];
            if (cand >= `MDC_NUM_DISP)
                cand = cand - `MDC_NUM_DISP;
            if (!found &&
                pages_of(cand[2:0], i_test_mode, i_bill_reg_cnt, i_dmd_reg_cnt,
                         i_tariff_cnt, i_disp_pages) != 8'h00 &&
                (state_q == ST_MANUAL || i_scroll_incl[cand[2:0]])) begin
                found    = 1'b1;
                nxt_slot = cand[2:0];
            end
        end
    end

    // ----------------------------------------
    // Main control
    // ----------------------------------------
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q      <= ST_MANUAL;
            bl_min_q     <= `MDC_BL_MIN_RST;
            ar_min_q     <= `MDC_AR_MIN_RST;
            scr_s_q      <= `MDC_SCR_S_RST;
            idle_q       <= 11'h000;
            step_q       <= 5'h00;
            slot_q       <= `MDC_DEFAULT_DISP;
            page_q       <= 8'h00;
            res_slot_q   <= `MDC_DEFAULT_DISP;
            res_page_q   <= 8'h00;
            o_backlight  <= 1'b1;
            o_setup_exit <= 1'b0;
        end else begin
            o_setup_exit <= 1'b0;
            // Clamp so a bad setting cannot stall the timers
            if (i_cfg_wr) begin
                if (i_backlight_min < `MDC_BL_MIN_LO)
                    bl_min_q <= `MDC_BL_MIN_LO;
                else if (i_backlight_min > `MDC_BL_MIN_HI)
                    bl_min_q <= `MDC_BL_MIN_HI;
                else
                    bl_min_q <= i_backlight_min;
                if (i_autoret_min < `MDC_AR_MIN_LO)
                    ar_min_q <= `MDC_AR_MIN_LO;
                else if (i_autoret_min > `MDC_AR_MIN_HI)
                    ar_min_q <= `MDC_AR_MIN_HI;
                else
                    ar_min_q <= i_autoret_min;
                if (i_scroll_sec < `MDC_SCR_S_LO)
                    scr_s_q <= `MDC_SCR_S_LO;
                else if (i_scroll_sec > `MDC_SCR_S_HI)
                    scr_s_q <= `MDC_SCR_S_HI;
                else
                    scr_s_q <= i_scroll_sec;
            end
            if (any_press) begin
                idle_q <= 11'h000;
                step_q <= 5'h00;
                if (!o_backlight) begin
                    o_backlight <= 1'b1;
                end else if (state_q == ST_SCROLL) begin
                    state_q    <= ST_MANUAL;
                    res_slot_q <= slot_q;
                    res_page_q <= page_q;
                end else if (!i_setup_active) begin
                    if (press_select) begin
                        slot_q <= nxt_slot;
                        page_q <= 8'h00;
                    end else if (last_page) begin
                        page_q <= 8'h00;
                    end else begin
                        page_q <= page_q + 8'h01;
                    end
                end
            end else if (i_sec_tick) begin
                idle_q <= idle_nx;
                if (o_backlight && !i_backlight_cont && idle_nx >= bl_lim)
                    o_backlight <= 1'b0;
                if (i_autoret_en && idle_nx == ar_lim) begin
                    slot_q       <= `MDC_DEFAULT_DISP;
                    page_q       <= 8'h00;
                    o_setup_exit <= i_setup_active;
                    if (i_autoscroll_en && !i_test_mode) begin
                        state_q <= ST_SCROLL;
                        step_q  <= 5'h00;
                    end
                end else if (!i_autoret_en && i_autoscroll_en && !i_test_mode &&
                             !i_setup_active && state_q == ST_MANUAL &&
                             idle_nx == start_lim) begin
                    state_q <= ST_SCROLL;
                    slot_q  <= res_slot_q;
                    page_q  <= res_page_q;
                    step_q  <= 5'h00;
                end else if (state_q == ST_SCROLL) begin
                    if (step_nx >= scr_s_q) begin
                        step_q <= 5'h00;
                        if (last_page) begin
                            slot_q <= nxt_slot;
                            page_q <= 8'h00;
                        end else begin
                            page_q <= page_q + 8'h01;
                        end
                    end else begin
                        step_q <= step_nx;
                    end
                end
            end
            // Scroll is also dropped when the feature is turned off
            if ((i_test_mode || !i_autoscroll_en) && state_q == ST_SCROLL) begin
                state_q    <= ST_MANUAL;
                res_slot_q <= slot_q;
                res_page_q <= page_q;
            end
        end
    end

    // Both billing slots give way to the single-page test view
    wire bill_slot;

    assign bill_slot = (slot_q == `MDC_DISP_BILL_ENERGY) || (slot_q == `MDC_DISP_BILL_DMD);

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_display          <= `MDC_DEFAULT_DISP;
            o_page             <= 8'h00;
            o_autoscroll       <= 1'b0;
            o_test_label       <= 1'b0;
            o_energy_unit      <= `MDC_UNIT_KILO;
            o_energy_frac      <= `MDC_ENERGY_FRAC;
            o_energy_digits    <= 4'h0;
            o_power_unit       <= `MDC_UNIT_KILO;
            o_power_frac       <= `MDC_POWER_FRAC;
            o_volt_unit        <= `MDC_UNIT_BASE;
            o_volt_frac        <= `MDC_VOLT_FRAC_DIR;
            o_curr_unit        <= `MDC_UNIT_BASE;
            o_curr_frac        <= `MDC_CURR_FRAC;
            o_test_energy_frac <= `MDC_TEST_ENERGY_FRAC;
        end else begin
            if (i_test_mode && bill_slot) begin
                o_display <= `MDC_DISP_TEST;
                o_page    <= 8'h00;
            end else begin
                o_display <= slot_q;
                o_page    <= page_q;
            end
            o_autoscroll    <= state_q;
            o_test_label    <= i_test_mode;
            o_energy_unit   <= `MDC_UNIT_KILO;
            o_energy_frac   <= `MDC_ENERGY_FRAC;
            o_energy_digits <= i_energy_digits;
            o_power_unit    <= i_pt_ratio_gt1 ? `MDC_UNIT_MEGA : `MDC_UNIT_KILO;
            o_power_frac    <= `MDC_POWER_FRAC;
            o_volt_unit     <= i_pt_ratio_gt1 ? `MDC_UNIT_KILO : `MDC_UNIT_BASE;
            o_volt_frac     <= i_pt_ratio_gt1 ? `MDC_VOLT_FRAC_PT : `MDC_VOLT_FRAC_DIR;
            o_curr_unit     <= `MDC_UNIT_BASE;
            o_curr_frac     <= `MDC_CURR_FRAC;
            o_test_energy_frac <= `MDC_TEST_ENERGY_FRAC;
        end
    end

endmodule

`default_nettype wire

/* verilog/meter_display_defines.vh */
`ifndef METER_DISPLAY_DEFINES_VH
`define METER_DISPLAY_DEFINES_VH

// ----------------------------------------
// Timing, in seconds and minutes
// ----------------------------------------
`define MDC_SEC_PER_MIN      11'h03c
`define MDC_IDLE_MAX         11'h7ff
`define MDC_BL_MIN_LO        4'h1
`define MDC_BL_MIN_HI        4'ha
`define MDC_BL_MIN_RST       4'h1
`define MDC_AR_MIN_LO        5'h01
`define MDC_AR_MIN_HI        5'h1e
`define MDC_AR_MIN_RST       5'h01
`define MDC_SETUP_RET_MIN    5'h05
`define MDC_SCROLL_START_MIN 5'h01
`define MDC_SCR_S_LO         5'h02
`define MDC_SCR_S_HI         5'h1e
`define MDC_SCR_S_RST        5'h05

// ----------------------------------------
// Display codes and order
// ----------------------------------------
`define MDC_NUM_DISP         4'h7
`define MDC_DISP_BILL_ENERGY 3'h0
`define MDC_DISP_BILL_DMD    3'h1
`define MDC_DISP_TEST        3'h7
`define MDC_DEFAULT_DISP     3'h0

// ----------------------------------------
// Units and resolution
// ----------------------------------------
`define MDC_UNIT_BASE        2'h0
`define MDC_UNIT_KILO        2'h1
`define MDC_UNIT_MEGA        2'h2
`define MDC_ENERGY_FRAC      2'h1
`define MDC_POWER_FRAC       2'h3
`define MDC_VOLT_FRAC_DIR    2'h1
`define MDC_VOLT_FRAC_PT     2'h3
`define MDC_CURR_FRAC        2'h2
`define MDC_TEST_ENERGY_FRAC 2'h3

`endif

/* verilog/button_sync.v */
`timescale 1ns/10ps
`default_nettype none

module button_sync (
    // Clock and reset
    input  wire i_core_clk,
    input  wire i_rstn,
    // Raw pin
    input  wire i_btn,
    // Press event
    output reg  o_press
);

    reg meta_q;
    reg sync_q;
    reg last_q;

    // ----------------------------------------
    // Two-stage synchroniser, edge on stage two
    // ----------------------------------------
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q  <= 1'b0;
            sync_q  <= 1'b0;
            last_q  <= 1'b0;
            o_press <= 1'b0;
        end else begin
            meta_q  <= i_btn;
            sync_q  <= meta_q;
            last_q  <= sync_q;
            o_press <= sync_q & ~last_q;
        end
    end

endmodule

`default_nettype wire

/* testbench/meter_display_control_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
`include "meter_display_defines.vh"

module meter_display_control_asserts (
    // Clock and reset
    input wire logic       i_core_clk,
    input wire logic       i_rstn,
    // Watched inputs
    input wire logic       i_btn_scroll,
    input wire logic       i_btn_select,
    input wire logic       i_backlight_cont,
    input wire logic [3:0] i_energy_digits,
    input wire logic       i_test_mode,
    input wire logic       i_setup_active,
    input wire logic       i_pt_ratio_gt1,
    // Watched outputs
    input wire logic       o_backlight,
    input wire logic [2:0] o_display,
    input wire logic [7:0] o_page,
    input wire logic       o_autoscroll,
    input wire logic       o_setup_exit,
    input wire logic       o_test_label,
    input wire logic [1:0] o_energy_unit,
    input wire logic [1:0] o_energy_frac,
    input wire logic [3:0] o_energy_digits,
    input wire logic [1:0] o_power_unit,
    input wire logic [1:0] o_power_frac,
    input wire logic [1:0] o_volt_unit,
    input wire logic [1:0] o_volt_frac,
    input wire logic [1:0] o_curr_unit,
    input wire logic [1:0] o_curr_frac,
    input wire logic [1:0] o_test_energy_frac
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    chk_dark_wake: assert property (
        !o_backlight && ($rose(i_btn_select) || $rose(i_btn_scroll)) |-> ##[3:5] o_backlight)
        else $error("press did not light backlight");
    chk_cont_lit: assert property (
        i_backlight_cont && o_backlight |=> o_backlight)
        else $error("backlight dimmed while continuous");
    chk_dark_hold: assert property (
        !o_backlight && ($rose(i_btn_select) || $rose(i_btn_scroll))
        |=> ($stable(o_autoscroll) && $stable(o_display) && $stable(o_page)) [*6])
        else $error("dark press changed view");
    chk_lit_stop: assert property (
        o_backlight && o_autoscroll && $rose(i_btn_scroll) |-> ##[4:6] !o_autoscroll)
        else $error("lit press did not stop scrolling");
    chk_test_noscroll: assert property (
        i_test_mode [*3] |-> !o_autoscroll)
        else $error("scrolling in test mode");
    chk_setup_exit: assert property (
        o_setup_exit |-> $past(i_setup_active)
        ##1 (!o_setup_exit && (i_test_mode || (o_display == 3'h0 && o_page == 8'h00))))
        else $error("setup exit pulse wrong");
    chk_test_label: assert property (
        $past(i_rstn) |-> o_test_label == $past(i_test_mode))
        else $error("test label does not follow mode");
    chk_power_scale: assert property (
        $past(i_rstn) |-> o_power_frac == `MDC_POWER_FRAC
        && o_power_unit == ($past(i_pt_ratio_gt1) ? `MDC_UNIT_MEGA : `MDC_UNIT_KILO))
        else $error("power scaling wrong");
    chk_volt_scale: assert property (
        $past(i_rstn) |-> ($past(i_pt_ratio_gt1)
        ? (o_volt_unit == `MDC_UNIT_KILO && o_volt_frac == `MDC_VOLT_FRAC_PT)
        : (o_volt_unit == `MDC_UNIT_BASE && o_volt_frac == `MDC_VOLT_FRAC_DIR)))
        else $error("voltage scaling wrong");
    chk_fixed_res: assert property (
        $past(i_rstn) |-> o_energy_digits == $past(i_energy_digits)
        && o_energy_unit == `MDC_UNIT_KILO && o_energy_frac == `MDC_ENERGY_FRAC
        && o_curr_unit == `MDC_UNIT_BASE && o_curr_frac == `MDC_CURR_FRAC
        && o_test_energy_frac == `MDC_TEST_ENERGY_FRAC)
        else $error("fixed resolution wrong");
endmodule
`default_nettype wire

/* testbench/panel_operator.sv */
`timescale 1ns/10ps
`default_nettype none

module panel_operator (
    // Clock
    input  wire logic i_core_clk,
    // One-cycle press requests
    input  wire logic i_push_scroll,
    input  wire logic i_push_select,
    // Button pins, high while held
    output wire logic o_btn_scroll,
    output wire logic o_btn_select
);
    logic [2:0] hold_q = 3'h0;
    logic       scr_q  = 1'b0;
    logic       sel_q  = 1'b0;

    assign o_btn_scroll = scr_q;
    assign o_btn_select = sel_q;
    // Held long enough for the synchroniser, released long enough not to merge
    always @(posedge i_core_clk) begin
        if (i_push_scroll || i_push_select) begin
            scr_q  <= i_push_scroll;
            sel_q  <= i_push_select;
            hold_q <= 3'h4;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
            if (hold_q == 3'h1) begin
                scr_q <= 1'b0;
                sel_q <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* testbench/tb_meter_display_control.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_meter_display_control;
    logic i_core_clk, i_rstn, i_sec_tick, i_cfg_wr, i_backlight_cont, i_autoret_en;
    logic i_autoscroll_en, i_test_mode, i_setup_active, i_pt_ratio_gt1, ps_scr, ps_sel;
    logic i_btn_scroll, i_btn_select, o_backlight, o_autoscroll, o_setup_exit, o_test_label;
    logic [3:0] i_backlight_min, i_energy_digits, i_bill_reg_cnt, i_dmd_reg_cnt, i_tariff_cnt;
    logic [4:0] i_autoret_min, i_scroll_sec;
    logic [6:0] i_scroll_incl;
    logic [19:0] i_disp_pages;
    logic [2:0] o_display;
    logic [7:0] o_page;
    int error_cnt = 0, checked = 0, exit_cnt = 0, bl, ss, n, s1, seed;

    meter_display_control uut (.i_core_clk, .i_rstn, .i_sec_tick, .i_btn_scroll, .i_btn_select,
        .i_cfg_wr, .i_backlight_min, .i_backlight_cont, .i_autoret_en, .i_autoret_min,
        .i_autoscroll_en, .i_scroll_sec, .i_scroll_incl, .i_energy_digits, .i_test_mode,
        .i_setup_active, .i_pt_ratio_gt1, .i_bill_reg_cnt, .i_dmd_reg_cnt, .i_tariff_cnt,
        .i_disp_pages, .o_backlight, .o_display, .o_page, .o_autoscroll, .o_setup_exit,
        .o_test_label, .o_energy_unit(), .o_energy_frac(), .o_energy_digits(), .o_power_unit(),
        .o_power_frac(), .o_volt_unit(), .o_volt_frac(), .o_curr_unit(), .o_curr_frac(),
        .o_test_energy_frac());
    panel_operator u_op (.i_core_clk, .i_push_scroll(ps_scr), .i_push_select(ps_sel),
        .o_btn_scroll(i_btn_scroll), .o_btn_select(i_btn_select));

    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    // Pulse is one cycle wide, so count it on the clock
    always @(posedge i_core_clk) if (o_setup_exit === 1'b1) exit_cnt <= exit_cnt + 1;

    // ----------------------------------------
    // Expectations and drivers
    // ----------------------------------------
    function automatic int pages(input int s);
        if (s == 0) return i_bill_reg_cnt * (i_tariff_cnt + 1);
        if (s == 1) return i_dmd_reg_cnt * (i_tariff_cnt + 1);
        return i_disp_pages[4*(s-2) +: 4];
    endfunction
    function automatic int next_slot(input int s);
        int k;
        k = (s + 1) % 7;
        while (pages(k) == 0) k = (k + 1) % 7;
        return k;
    endfunction
    function automatic int next_inc(input int s);
        int k;
        k = (s + 1) % 7;
        while (pages(k) == 0 || !i_scroll_incl[k]) k = (k + 1) % 7;
        return k;
    endfunction
    task automatic close_out;
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic push(input logic sel);
        @(negedge i_core_clk);
        ps_scr = !sel;
        ps_sel = sel;
        @(negedge i_core_clk);
        ps_scr = 1'b0;
        ps_sel = 1'b0;
        repeat (12) @(negedge i_core_clk);
    endtask
    // Fast tick keeps minute-long timers short
    task automatic ticks(input int k);
        repeat (k) begin
            @(negedge i_core_clk);
            i_sec_tick = 1'b1;
            i_pt_ratio_gt1 = 1'($urandom);
            i_energy_digits = 4'($urandom);
            @(negedge i_core_clk);
            i_sec_tick = 1'b0;
            repeat (2) @(negedge i_core_clk);
        end
    endtask
    task automatic cfg(input int b, input int s);
        @(negedge i_core_clk);
        i_backlight_min = 4'(b);
        i_scroll_sec = 5'(s);
        i_cfg_wr = 1'b1;
        @(negedge i_core_clk);
        i_cfg_wr = 1'b0;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = $urandom(32'hbc8b);
        {i_rstn, i_sec_tick, i_cfg_wr, i_backlight_cont, i_autoret_en, ps_scr, ps_sel} = 7'h00;
        {i_autoscroll_en, i_test_mode, i_setup_active, i_pt_ratio_gt1} = 4'h0;
        i_backlight_min = 4'h1;
        i_energy_digits = 4'h6;
        i_autoret_min = 5'h01;
        i_scroll_sec = 5'h05;
        i_scroll_incl = 7'h7f;
        i_bill_reg_cnt = 4'h2;
        i_dmd_reg_cnt = 4'h1;
        i_tariff_cnt = 4'h3;
        // Slot 4 left empty so the skip is exercised
        i_disp_pages = {4'(1 + $urandom % 15), 4'(1 + $urandom % 15), 4'h0,
                        4'(1 + $urandom % 15), 4'(1 + $urandom % 15)};
        repeat (8) @(negedge i_core_clk);
        i_rstn = 1'b1;
        repeat (2) @(negedge i_core_clk);
        chk({o_backlight, o_autoscroll, o_display}, 8'h10, "reset state");
        chk(o_page, 8'h00, "reset page");
        n = 0;
        repeat (7) begin
            push(1'b1);
            n = next_slot(n);
            chk(o_display, 8'(n), "display order");
        end
        for (int p = 1; p <= 8; p++) begin
            push(1'b0);
            chk(o_page, 8'(p % pages(n)), "billing pages");
        end
        bl = 1 + $urandom % 10;
        cfg(bl, 5);
        push(1'b0);
        ticks(bl * 60 - 1);
        chk(o_backlight, 8'h01, "backlight early off");
        ticks(1);
        chk(o_backlight, 8'h00, "backlight not dimmed");
        push(1'b1);
        chk({o_backlight, o_display}, 8'(8 + n), "dark press navigated");
        chk(o_page, 8'h01, "dark press paged");
        i_backlight_cont = 1'b1;
        ticks(bl * 60 + 3);
        chk(o_backlight, 8'h01, "continuous backlight");
        i_backlight_cont = 1'b0;
        i_autoret_en = 1'b1;
        push(1'b1);
        push(1'b1);
        ticks(59);
        chk(o_display, 8'(next_slot(next_slot(n))), "early return");
        ticks(1);
        chk({o_display, o_page[4:0]}, 8'h00, "auto return");
        i_setup_active = 1'b1;
        n = exit_cnt;
        push(1'b0);
        ticks(299);
        chk(8'(exit_cnt - n), 8'h00, "early setup exit");
        ticks(1);
        chk(8'(exit_cnt - n), 8'h01, "setup exit");
        i_setup_active = 1'b0;
        ss = 2 + $urandom % 29;
        cfg(1, ss);
        i_scroll_incl = 7'($urandom) | 7'h01;
        i_autoscroll_en = 1'b1;
        push(1'b0);
        ticks(59);
        chk(o_autoscroll, 8'h00, "early scroll");
        ticks(1);
        chk({o_autoscroll, o_display}, 8'h08, "scroll on return");
        n = 0;
        while (o_page === 8'h00 && n < 40) begin
            ticks(1);
            n++;
        end
        chk(8'(n), 8'(ss), "scroll interval");
        if (n == 40) close_out();
        s1 = next_inc(0);
        ticks(ss * (pages(0) - 1));
        chk(o_display, 8'(s1), "scroll inclusion");
        chk(o_backlight, 8'h00, "backlight on while idle");
        push(1'b0);
        chk({o_backlight, o_autoscroll}, 8'h03, "first dark press");
        push(1'b0);
        chk(o_autoscroll, 8'h00, "scroll not stopped");
        i_autoret_en = 1'b0;
        push(1'b1);
        ticks(59);
        chk({o_autoscroll, o_display}, 8'(next_slot(s1)), "early resume");
        ticks(1);
        chk({o_autoscroll, o_display}, 8'(8 + s1), "resume display");
        chk(o_page, 8'h00, "resume page");
        i_test_mode = 1'b1;
        repeat (4) @(negedge i_core_clk);
        chk({o_autoscroll, o_test_label, o_display}, 8'(8 + ((s1 < 2) ? 7 : s1)),
            "test display");
        push(1'b0);
        ticks(65);
        chk(o_autoscroll, 8'h00, "scroll in test");
        i_test_mode = 1'b0;
        close_out();
    end
endmodule

bind meter_display_control meter_display_control_asserts u_chk (.i_core_clk, .i_rstn,
    .i_btn_scroll, .i_btn_select, .i_backlight_cont, .i_energy_digits, .i_test_mode,
    .i_setup_active, .i_pt_ratio_gt1, .o_backlight, .o_display, .o_page, .o_autoscroll,
    .o_setup_exit, .o_test_label, .o_energy_unit, .o_energy_frac, .o_energy_digits,
    .o_power_unit, .o_power_frac, .o_volt_unit, .o_volt_frac, .o_curr_unit, .o_curr_frac,
    .o_test_energy_frac);
`default_nettype wire
